// ===== verilog/csd_cfg.svh
// Purpose: constants for the chip-select base/mask decoder
// Assumes: 32-bit AXI4-Lite byte addresses
// Notes:   offsets are full byte addresses
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH
`define CSD_OFS_SEL0      32'hFFFF_E400
`define CSD_OFS_SEL1      32'hFFFF_E404
`define CSD_OFS_SEL2      32'hFFFF_E408
`define CSD_OFS_SEL3      32'hFFFF_E40C
`define CSD_OFS_STATUS    32'hFFFF_E410
`define CSD_RST_SEL01     32'h0000_03FF
`define CSD_RST_SEL23     32'h0000_01FF
`define CSD_SHIFT_SEL01   5'h0E
`define CSD_SHIFT_SEL23   5'h0F
`define CSD_BASE_LSB      16
`define CSD_RESP_OKAY     2'h0
`define CSD_RESP_SLVERR   2'h2
`endif

// ===== verilog/csd_pkg.sv
// Purpose: types for the chip-select base/mask decoder
// Assumes: AXI4-Lite with 32-bit data
// Notes:   request travels master to slave, response back
package csd_pkg;
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } csd_axi_req_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } csd_axi_rsp_type;
  typedef struct packed {
    logic        hit;
    logic [2:0]  index;
  } csd_reg_sel_type;
endpackage

// ===== verilog/csd_decoder.sv
// Purpose: four-space chip-select address decoder with base/mask registers
// Assumes: busAddr/busValid come from logic on sys_clk; registers over AXI4-Lite
// Notes:   select outputs are registered, one cycle after the address
// Summary of operation
// - Set mask bit drops address bit from compare
// - Only unmasked bits compared against start address
// - Spaces zero/one mask bits cover A29..A14
// - Spaces two/three mask bits cover A30..A15
// - Bits 31..16 hold start address A31..A16
// - Spaces zero/one sizes 16 KB to 1 GB
// - Spaces two/three sizes 32 KB to 2 GB
// - Start address low sixteen bits are zero
// - A31/A30 always compared, A31 for two/three
// - Compare runs on every bus cycle
// - Only highest-priority matching space selected
`timescale 1ns/10ps
`include "csd_cfg.svh"
module csd_decoder
  import csd_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire csd_axi_req_type axiReq,
  output csd_axi_rsp_type      axiRsp,
  input  wire logic [31:0]     busAddr,
  input  wire logic            busValid,
  output logic [3:0]           spaceSelect,
  output logic                 selHit
);

  logic [31:0] spaceBaseMaskReg [4];
  logic [31:0] next_spaceBaseMaskReg [4];
  logic [3:0]  lastSelect, next_lastSelect;
  logic [3:0]  next_spaceSelect;
  logic        next_selHit;
  logic [3:0]  matchVec;

  // Address compare of one space; mask field shifted onto its address bits
  function automatic logic spaceMatch(input logic [31:0] addr, input logic [31:0] bm, input logic [4:0] sh);
    logic [31:0] maskBits;
    logic [31:0] careBits;
    maskBits = {16'h0000, bm[15:0]} << sh;
    careBits = ~maskBits & ~((32'h0000_0001 << sh) - 32'h0000_0001);
    return ((addr ^ {bm[31:`CSD_BASE_LSB], 16'h0000}) & careBits) == 32'h0000_0000;
  endfunction

  // Register decode shared by read and write paths
  function automatic csd_reg_sel_type regDecode(input logic [31:0] addr);
    regDecode = '{hit: 1'b1, index: 3'h0};
    case (addr)
      `CSD_OFS_SEL0:   regDecode.index = 3'h0;
      `CSD_OFS_SEL1:   regDecode.index = 3'h1;
      `CSD_OFS_SEL2:   regDecode.index = 3'h2;
      `CSD_OFS_SEL3:   regDecode.index = 3'h3;
      `CSD_OFS_STATUS: regDecode.index = 3'h4;
      default:         regDecode.hit = 1'b0;
    endcase
  endfunction

  // Match every space every cycle, then priority select
  always_comb begin
    matchVec[0] = spaceMatch(busAddr, spaceBaseMaskReg[0], `CSD_SHIFT_SEL01);
    matchVec[1] = spaceMatch(busAddr, spaceBaseMaskReg[1], `CSD_SHIFT_SEL01);
    matchVec[2] = spaceMatch(busAddr, spaceBaseMaskReg[2], `CSD_SHIFT_SEL23);
    matchVec[3] = spaceMatch(busAddr, spaceBaseMaskReg[3], `CSD_SHIFT_SEL23);
    next_spaceSelect = 4'h0;
    if (busValid) begin
      if (matchVec[0]) next_spaceSelect = 4'h1;
      else if (matchVec[1]) next_spaceSelect = 4'h2;
      else if (matchVec[2]) next_spaceSelect = 4'h4;
      else if (matchVec[3]) next_spaceSelect = 4'h8;
    end
    next_selHit = |next_spaceSelect;
    next_lastSelect = next_selHit ? next_spaceSelect : lastSelect;
  end

  // Select outputs and status capture
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spaceSelect <= 4'h0;
      selHit      <= 1'b0;
      lastSelect  <= 4'h0;
    end else begin
      spaceSelect <= next_spaceSelect;
      selHit      <= next_selHit;
      lastSelect  <= next_lastSelect;
    end
  end

  // Write channel state
  logic        awHeld, next_awHeld, wHeld, next_wHeld;
  logic [31:0] awAddr, next_awAddr, wData, next_wData;
  logic [3:0]  wStrb, next_wStrb;
  logic        awReady, next_awReady, wReady, next_wReady;
  logic        bValid, next_bValid;
  logic [1:0]  bResp, next_bResp;
  csd_reg_sel_type wSel;

  // Address and data taken in either order; response once both are held
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bValid = bValid;
    next_bResp  = bResp;
    next_spaceBaseMaskReg = spaceBaseMaskReg;
    wSel = regDecode(awAddr);
    if (bValid && axiReq.bready) next_bValid = 1'b0;
    if (axiReq.awvalid && awReady) begin
      next_awHeld = 1'b1;
      next_awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && wReady) begin
      next_wHeld = 1'b1;
      next_wData = axiReq.wdata;
      next_wStrb = axiReq.wstrb;
    end
    if (awHeld && wHeld && !bValid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bValid = 1'b1;
      next_bResp  = `CSD_RESP_SLVERR;
      if (wSel.hit && wSel.index < 3'h4) begin
        next_bResp = `CSD_RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (wStrb[b]) next_spaceBaseMaskReg[wSel.index[1:0]][b*8 +: 8] = wData[b*8 +: 8];
        end
      end
    end
    next_awReady = !next_awHeld && !next_bValid;
    next_wReady  = !next_wHeld && !next_bValid;
  end

  // Write channel registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld  <= 1'b0;
      awAddr  <= 32'h0000_0000;
      wHeld   <= 1'b0;
      wData   <= 32'h0000_0000;
      wStrb   <= 4'h0;
      awReady <= 1'b1;
      wReady  <= 1'b1;
      bValid  <= 1'b0;
      bResp   <= `CSD_RESP_OKAY;
      spaceBaseMaskReg[0] <= `CSD_RST_SEL01;
      spaceBaseMaskReg[1] <= `CSD_RST_SEL01;
      spaceBaseMaskReg[2] <= `CSD_RST_SEL23;
      spaceBaseMaskReg[3] <= `CSD_RST_SEL23;
    end else begin
      awHeld  <= next_awHeld;
      awAddr  <= next_awAddr;
      wHeld   <= next_wHeld;
      wData   <= next_wData;
      wStrb   <= next_wStrb;
      awReady <= next_awReady;
      wReady  <= next_wReady;
      bValid  <= next_bValid;
      bResp   <= next_bResp;
      spaceBaseMaskReg <= next_spaceBaseMaskReg;
    end
  end

  // Read channel state
  logic        arReady, next_arReady, rValid, next_rValid;
  logic [31:0] rData, next_rData;
  logic [1:0]  rResp, next_rResp;
  csd_reg_sel_type rSel;

  // Read answered on the same edge that takes the address
  always_comb begin
    next_rValid = rValid;
    next_rData  = rData;
    next_rResp  = rResp;
    rSel = regDecode(axiReq.araddr);
    if (rValid && axiReq.rready) next_rValid = 1'b0;
    if (axiReq.arvalid && arReady) begin
      next_rValid = 1'b1;
      next_rResp  = rSel.hit ? `CSD_RESP_OKAY : `CSD_RESP_SLVERR;
      next_rData  = 32'h0000_0000;
      if (rSel.hit) begin
        next_rData = (rSel.index == 3'h4) ? {28'h000_0000, lastSelect} : spaceBaseMaskReg[rSel.index[1:0]];
      end
    end
    next_arReady = !next_rValid;
  end

  // Read channel registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arReady <= 1'b1;
      rValid  <= 1'b0;
      rData   <= 32'h0000_0000;
      rResp   <= `CSD_RESP_OKAY;
    end else begin
      arReady <= next_arReady;
      rValid  <= next_rValid;
      rData   <= next_rData;
      rResp   <= next_rResp;
    end
  end

  // Response bundle from the flops above
  assign axiRsp = '{awready: awReady, wready: wReady, bvalid: bValid, bresp: bResp,
                    arready: arReady, rvalid: rValid, rdata: rData, rresp: rResp};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Checks on the select path and the write response
  sel_onehot_a: assert property (1'b1 |-> $onehot0(spaceSelect)) else $error("more than one select");
  prio_zero_a: assert property (busValid && matchVec[0] |=> spaceSelect == 4'h1) else $error("space zero lost");
  every_cycle_a: assert property (busValid && (|matchVec) |=> selHit) else $error("match missed");
  top_zero_a: assert property (spaceSelect[0] |-> $past(busAddr[31:30]) == $past(spaceBaseMaskReg[0][31:30]))
    else $error("A31/A30 not compared");
  top_two_a: assert property (spaceSelect[2] |-> $past(busAddr[31]) == $past(spaceBaseMaskReg[2][31]))
    else $error("A31 not compared");
  full_cmp_a: assert property (spaceSelect[1] && $past(spaceBaseMaskReg[1][15:0]) == 16'h0000
    |-> $past(busAddr[31:14]) == {$past(spaceBaseMaskReg[1][31:16]), 2'b00}) else $error("base compare wrong");
  mask_one_a: assert property (busValid && spaceBaseMaskReg[0][15:0] == 16'h03FF
    && busAddr[31:24] == spaceBaseMaskReg[0][31:24] |=> spaceSelect[0]) else $error("mask not applied");
  mask_two_a: assert property (busValid && matchVec[1:0] == 2'b00 && spaceBaseMaskReg[2][15:0] == 16'h01FF
    && busAddr[31:24] == spaceBaseMaskReg[2][31:24] |=> spaceSelect[2]) else $error("space two mask wrong");
  low_bit_a: assert property (busValid && spaceBaseMaskReg[0][15:0] == 16'h0001
    && busAddr[31:15] == {spaceBaseMaskReg[0][31:16], 1'b0} |=> spaceSelect[0]) else $error("A14 mask wrong");
  resp_hold_a: assert property (bValid && !axiReq.bready |=> bValid && $stable(bResp)) else $error("bresp dropped");

  overlap_c: cover property (busValid && matchVec[0] && matchVec[1]);
  space3_c: cover property (spaceSelect == 4'h8);
  write_c: cover property (bValid && axiReq.bready && bResp == `CSD_RESP_OKAY);
  read_c: cover property (rValid && axiReq.rready);

endmodule // csd_decoder

// ===== test/csd_addr_source.sv
// Purpose: address source standing in for the core and DMA masters
// Assumes: one address offered per call, on sys_clk
// Notes:   an idle bus shows the inverted last address
`timescale 1ns/10ps
module csd_addr_source (
  output logic [31:0] busAddr,
  output logic        busValid,
  input  wire logic   sys_clk
);
  // Idle bus at time zero
  initial begin
    busAddr  = 32'h0000_0000;
    busValid = 1'b0;
  end
  // One cycle of physical address, then idle with a changed address
  task automatic issue(input logic [31:0] a, input logic v);
    @(posedge sys_clk);
    busAddr  <= a;
    busValid <= v;
    @(posedge sys_clk);
    busAddr  <= ~a;
    busValid <= 1'b0;
  endtask
endmodule // csd_addr_source

// ===== test/tb_chip_select_base_mask_decoder.sv
// Purpose: self-checking bench for the chip-select decoder
// Assumes: AXI4-Lite register access, select one cycle after address
// Notes:   over-wide masks are written on purpose to reach size limits
`timescale 1ns/10ps
module tb_chip_select_base_mask_decoder
  import csd_pkg::*;
;
  logic            sys_clk;
  logic            rst_b;
  csd_axi_req_type axiReq;
  csd_axi_rsp_type axiRsp;
  logic [31:0]     busAddr;
  logic            busValid;
  logic [3:0]      spaceSelect;
  logic            selHit;
  int              failures;
  int              samples_checked;
  csd_decoder dut (.sys_clk(sys_clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp),
    .busAddr(busAddr), .busValid(busValid), .spaceSelect(spaceSelect), .selHit(selHit));
  csd_addr_source src (.busAddr(busAddr), .busValid(busValid), .sys_clk(sys_clk));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Write one word and wait for the response
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic ok;
    n  = 0;
    ok = 1'b0;
    axiReq.awaddr  <= a;
    axiReq.awvalid <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= 4'hF;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    while (!ok && n < 100) begin
      @(posedge sys_clk);
      n++;
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid === 1'b1) begin
        ok = 1'b1;
        axiReq.bready <= 1'b0;
        chk(32'(axiRsp.bresp), 32'(er));
      end
    end
    chk(32'(ok), 32'h0000_0001);
    @(posedge sys_clk);
  endtask
  // Read one word and compare data and response
  task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int   n;
    logic ok;
    n  = 0;
    ok = 1'b0;
    axiReq.araddr  <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    while (!ok && n < 100) begin
      @(posedge sys_clk);
      n++;
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid === 1'b1) begin
        ok = 1'b1;
        axiReq.rready <= 1'b0;
        chk(axiRsp.rdata, ed);
        chk(32'(axiRsp.rresp), 32'(er));
      end
    end
    chk(32'(ok), 32'h0000_0001);
    @(posedge sys_clk);
  endtask
  // Offer an address and check the selects in the following cycle
  task automatic probe(input logic [31:0] a, input logic v, input logic [3:0] e);
    src.issue(a, v);
    #1;
    chk({27'h0, selHit, spaceSelect}, {27'h0, |e, e});
  endtask
  task automatic test_regs;
    probe(32'h00AB_CDEF, 1'b1, 4'h1);
    axr(32'hFFFF_E400, 32'h0000_03FF, 2'h0);
    axr(32'hFFFF_E404, 32'h0000_03FF, 2'h0);
    axr(32'hFFFF_E408, 32'h0000_01FF, 2'h0);
    axr(32'hFFFF_E40C, 32'h0000_01FF, 2'h0);
    axw(32'hFFFF_E404, 32'hC000_0003, 2'h0);
    axr(32'hFFFF_E404, 32'hC000_0003, 2'h0);
    axr(32'hFFFF_E414, 32'h0000_0000, 2'h2);
    axw(32'hFFFF_E410, 32'h0000_000F, 2'h2);
    $display("test_regs done");
  endtask
  task automatic test_sizes;
    axw(32'hFFFF_E400, 32'hC000_0000, 2'h0);
    probe(32'h0012_3456, 1'b1, 4'h4);
    axw(32'hFFFF_E408, 32'hD000_0000, 2'h0);
    axw(32'hFFFF_E40C, 32'hD000_0001, 2'h0);
    probe(32'hC000_3FFF, 1'b1, 4'h1);
    probe(32'hC000_4000, 1'b1, 4'h2);
    probe(32'hC000_FFFF, 1'b1, 4'h2);
    probe(32'hC001_0000, 1'b1, 4'h0);
    probe(32'hC000_0000, 1'b0, 4'h0);
    probe(32'hD000_7FFF, 1'b1, 4'h4);
    probe(32'hD000_8000, 1'b1, 4'h8);
    probe(32'hD001_0000, 1'b1, 4'h0);
    axr(32'hFFFF_E410, 32'h0000_0008, 2'h0);
    $display("test_sizes done");
  endtask
  task automatic test_wide;
    axw(32'hFFFF_E400, 32'h0000_FFFF, 2'h0);
    axw(32'hFFFF_E408, 32'h0000_FFFF, 2'h0);
    probe(32'h3FFF_FFFF, 1'b1, 4'h1);
    probe(32'h4000_0000, 1'b1, 4'h4);
    probe(32'h8000_0000, 1'b1, 4'h0);
    // Lowest mask bit alone doubles space zero to 32 KB
    axw(32'hFFFF_E400, 32'hC000_0001, 2'h0);
    probe(32'hC000_7FFF, 1'b1, 4'h1);
    probe(32'hC000_8000, 1'b1, 4'h2);
    $display("test_wide done");
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    axiReq = '0;
    rst_b  = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    test_regs;
    test_sizes;
    test_wide;
    print_verdict;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    print_verdict;
  end
endmodule // tb_chip_select_base_mask_decoder
